// ### logic/cmpctl_event.sv
// Result change flag, interrupt request and low-power wake of the comparator
module cmpctl_event (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_status,        // Polarity-corrected result
  input wire logic i_comparator_on, // Core enabled
  input wire logic i_low_power,     // Device in sleep or idle
  input wire logic i_flag_we,       // Software writes the flag
  input wire logic i_flag_wdata,    // Value written to the flag
  input wire logic i_enable,        // Interrupt enable
  output logic o_flag,
  output logic o_irq,
  output logic o_wake
);
  import cmpctl_pkg::*;

  logic status_prev_reg; // Result seen last cycle
  logic flag_reg;        // Sticky change flag
  logic flag_next;
  logic wake_reg;        // One-cycle wake pulse
  logic wake_next;
  wire logic changed;    // Result bit toggled

  // ========================================================================
  // Change detection on the status bit, not on the pin
  // ========================================================================
  assign changed = i_status != status_prev_reg; // R8

  // Hardware set wins over a software write in the same cycle
  assign flag_next = changed ? 1'b1 : (i_flag_we ? i_flag_wdata : flag_reg);

  // A flag already pending suppresses the wake, so software can mask it
  assign wake_next = i_low_power & i_comparator_on & changed & ~flag_reg; // R9

  // Flags and history
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_prev_reg <= 1'b0;
      flag_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      status_prev_reg <= i_status;
      flag_reg <= flag_next; // R8
      wake_reg <= wake_next;
    end
  end

  assign o_flag = flag_reg;
  assign o_irq = flag_reg & i_enable; // R8
  assign o_wake = wake_reg;

  // ========================================================================
  // Checks
  // ========================================================================
  property p_flag_on_change;
    @(posedge i_clk) disable iff (i_rst)
    changed |=> o_flag;
  endproperty
  a_flag_on_change: assert property (p_flag_on_change) // R8
    else $error("flag not set after result change");

  property p_irq_gate;
    @(posedge i_clk) disable iff (i_rst)
    o_irq == (o_flag && i_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R8
    else $error("interrupt request does not follow flag and enable");

  property p_wake_cause;
    @(posedge i_clk) disable iff (i_rst)
    o_wake |-> $past(i_low_power) && $past(i_comparator_on) && o_flag
      && !$past(o_flag);
  endproperty
  a_wake_cause: assert property (p_wake_cause) // R9
    else $error("wake without a fresh change in low power");

endmodule : cmpctl_event

// ### logic/cmpctl_params.svh
// Offsets, field positions and reset values of the comparator control block
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH

// ==========================================================================
// Register byte addresses on the Wishbone slave
// ==========================================================================
`define CMPCTL_ADDR_CONTROL 4'h0
`define CMPCTL_ADDR_EVENT 4'h4
`define CMPCTL_ADDR_PORT 4'h8
`define CMPCTL_ADDR_PIN_READ 4'hc

// ==========================================================================
// Field positions of comparator0_control
// ==========================================================================
`define CMPCTL_BIT_PIN_SELECT 7
`define CMPCTL_BIT_COMPARATOR_ON 6
`define CMPCTL_BIT_OUTPUT_POLARITY 5
`define CMPCTL_BIT_RESULT_STATUS 4
`define CMPCTL_BIT_OUTPUT_ROUTE 3
`define CMPCTL_BIT_HYSTERESIS_ON 0

// ==========================================================================
// Field positions of the event and port registers
// ==========================================================================
`define CMPCTL_BIT_EVENT_FLAG 0
`define CMPCTL_BIT_EVENT_ENABLE 1
`define CMPCTL_LSB_PORT_DATA 0
`define CMPCTL_LSB_PORT_CONTROL 4
`define CMPCTL_LSB_PORT_PULLHIGH 8

// ==========================================================================
// Reset values
// ==========================================================================
`define CMPCTL_CONTROL_RESET 8'h81
`define CMPCTL_PORT_DATA_RESET 3'h0
`define CMPCTL_PORT_CONTROL_RESET 3'h7
`define CMPCTL_PORT_PULLHIGH_RESET 3'h0

`endif

// ### logic/cmpctl_pinmux.sv
// Shared pin multiplexer of the comparator and its port readback
module cmpctl_pinmux (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire cmpctl_pkg::cmpctl_ctrl_s i_ctrl,
  input wire logic i_status,         // Result shown on the output pin
  input wire logic [2:0] i_port_data,
  input wire logic [2:0] i_port_control, // 1 is input
  input wire logic [2:0] i_port_pullhigh,
  input wire logic [2:0] i_pin_in,
  output cmpctl_pkg::cmpctl_pins_s o_pins,
  output logic [2:0] o_pin_read
);
  import cmpctl_pkg::*;

  wire logic [2:0] claimed; // Pin taken by the comparator

  // ========================================================================
  // Ownership: both inputs follow pin select, output needs the route too
  // ========================================================================
  assign claimed[0] = i_ctrl.pin_select; // R1
  assign claimed[1] = i_ctrl.pin_select; // R1
  assign claimed[2] = i_ctrl.pin_select & ~i_ctrl.output_route_select; // R6

  // ========================================================================
  // Per-pin drive and readback
  // ========================================================================
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      if (g == 2) begin : g_result
        // Result pin carries the status bit while routed out
        assign o_pins.out[g] = claimed[g] ? i_status : i_port_data[g]; // R6
        assign o_pins.oe[g] = claimed[g] | ~i_port_control[g];
      end else begin : g_input
        // Input pins lose their I/O drive while claimed
        assign o_pins.out[g] = i_port_data[g];
        assign o_pins.oe[g] = ~claimed[g] & ~i_port_control[g]; // R2
      end
      // Pull-high is cut while claimed, and never fights an output
      assign o_pins.pullhigh[g] = i_port_pullhigh[g] & i_port_control[g]
        & ~claimed[g]; // R2
      // Claimed pins read zero as input, port data as output
      assign o_pin_read[g] = claimed[g]
        ? (i_port_control[g] ? 1'b0 : i_port_data[g]) // R10
        : (i_port_control[g] ? i_pin_in[g] : i_port_data[g]);
    end
  endgenerate

  // ========================================================================
  // Checks
  // ========================================================================
  property p_inputs_released;
    @(posedge i_clk) disable iff (i_rst)
    i_ctrl.pin_select |-> o_pins.oe[1:0] == 2'h0
      && o_pins.pullhigh[1:0] == 2'h0;
  endproperty
  a_inputs_released: assert property (p_inputs_released) // R2
    else $error("claimed input pin still driven or pulled high");

  property p_route_out;
    @(posedge i_clk) disable iff (i_rst)
    (i_ctrl.pin_select && !i_ctrl.output_route_select)
      |-> o_pins.oe[2] && o_pins.out[2] == i_status;
  endproperty
  a_route_out: assert property (p_route_out) // R6
    else $error("result not on output pin when routed out");

  property p_port_read;
    @(posedge i_clk) disable iff (i_rst)
    i_ctrl.pin_select |-> o_pin_read[0] ==
      (i_port_control[0] ? 1'b0 : i_port_data[0]);
  endproperty
  a_port_read: assert property (p_port_read) // R10
    else $error("claimed pin readback wrong");

endmodule : cmpctl_pinmux

// ### logic/cmpctl_pkg.sv
// Types shared by the comparator control block
package cmpctl_pkg;

  // ========================================================================
  // Control fields held by comparator0_control
  // ========================================================================
  typedef struct packed {
    logic pin_select;          // Shared pins given to the comparator
    logic comparator_on;       // Core powered
    logic output_polarity;     // Invert result
    logic output_route_select; // 1 keeps the result internal
    logic hysteresis_on;       // Forwarded to the analog core
  } cmpctl_ctrl_s;

  // ========================================================================
  // Drive of the three shared pins: 0 positive, 1 negative, 2 result
  // ========================================================================
  typedef struct packed {
    logic [2:0] out;      // Output level
    logic [2:0] oe;       // High while the block drives the pin
    logic [2:0] pullhigh; // Pull-high connected
  } cmpctl_pins_s;

  // ========================================================================
  // Bus answer sequencer, one-hot
  // ========================================================================
  typedef enum logic [1:0] {
    CMPCTL_BUS_IDLE = 2'b01,
    CMPCTL_BUS_ACK = 2'b10
  } cmpctl_bus_e;

endpackage : cmpctl_pkg

// ### logic/cmpctl_top.sv
// Comparator control register bank with Wishbone slave, pins and events
//
// Overview of operation
// R1: Bit 7 hands both input pins to comparator
// R2: Claimed input pins lose drive and pull-high
// R3: Bit 6 cleared keeps comparator powered down
// R4: Bit 5 inverts the comparator result
// R5: Bit 4 reads the polarity-corrected result, read-only
// R6: Result reaches pin only if route 0, select 1
// R7: Bits 2,1 read zero; bit 0 hysteresis stored
// R8: Status change sets flag; enabled flag requests interrupt
// R9: Change in low power wakes unless flag pending; the code wakes only while bit 6 (comparator on) is set
// R10: Claimed pins read zero or port data
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`include "cmpctl_params.svh"

module cmpctl_top (
  input wire logic i_clk,
  input wire logic i_rst,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Analog core
  input wire logic i_core_result, // High when positive above negative
  output logic o_comparator_on,
  output logic o_hysteresis_on,
  // Shared pins
  input wire logic [2:0] i_pin_in,
  output cmpctl_pkg::cmpctl_pins_s o_pins,
  // System
  input wire logic i_low_power, // Sleep or idle
  output logic o_irq,           // Comparator interrupt request
  output logic o_wake           // Wake pulse
);
  import cmpctl_pkg::*;

  // ========================================================================
  // Storage
  // ========================================================================
  cmpctl_bus_e bus_state_reg; // Answer sequencer
  cmpctl_bus_e bus_state_next;
  logic [7:0] control_reg;    // comparator0_control, bit 4 unused here
  logic [7:0] control_next;
  logic status_reg;           // Polarity-corrected result
  logic enable_reg;           // Interrupt enable
  logic enable_next;
  logic [2:0] port_data_reg;  // Port data register
  logic [2:0] port_data_next;
  logic [2:0] port_control_reg; // Port control, 1 is input
  logic [2:0] port_control_next;
  logic [2:0] port_pullhigh_reg; // Pull-high selection
  logic [2:0] port_pullhigh_next;
  logic [31:0] rdata_reg;     // Read data held for the answer
  logic [31:0] rdata_next;

  // ========================================================================
  // Decoded fields and bus strobes
  // ========================================================================
  cmpctl_ctrl_s ctrl;          // Control fields view
  wire logic request;          // New access seen in idle
  wire logic wr;               // Write accepted this edge
  wire logic hit_control;
  wire logic hit_event;
  wire logic hit_port;
  wire logic hit_pin_read;
  wire logic core_seen;        // Core result after power gating
  wire logic status_next;
  wire logic flag;             // Sticky change flag
  wire logic [2:0] pin_read;   // Port readback with pin sharing
  wire logic [7:0] control_view; // Control as software reads it
  wire logic flag_we;

  assign ctrl.pin_select = control_reg[`CMPCTL_BIT_PIN_SELECT];
  assign ctrl.comparator_on = control_reg[`CMPCTL_BIT_COMPARATOR_ON];
  assign ctrl.output_polarity = control_reg[`CMPCTL_BIT_OUTPUT_POLARITY];
  assign ctrl.output_route_select = control_reg[`CMPCTL_BIT_OUTPUT_ROUTE];
  assign ctrl.hysteresis_on = control_reg[`CMPCTL_BIT_HYSTERESIS_ON];

  // Only a request met in idle is taken, so each access acts once
  assign request = i_wb_cyc & i_wb_stb & (bus_state_reg == CMPCTL_BUS_IDLE);
  assign wr = request & i_wb_we;

  // Address decode; the low two address bits are ignored
  assign hit_control = i_wb_adr[3:2] == 2'(`CMPCTL_ADDR_CONTROL >> 2);
  assign hit_event = i_wb_adr[3:2] == 2'(`CMPCTL_ADDR_EVENT >> 2);
  assign hit_port = i_wb_adr[3:2] == 2'(`CMPCTL_ADDR_PORT >> 2);
  assign hit_pin_read = i_wb_adr[3:2] == 2'(`CMPCTL_ADDR_PIN_READ >> 2);

  // ========================================================================
  // Result path
  // ========================================================================
  // A powered-down core gives no result; treat it as low
  assign core_seen = ctrl.comparator_on & i_core_result; // R3
  assign status_next = core_seen ^ ctrl.output_polarity; // R4

  // Status bit slotted into the control view; bits 2 and 1 stay zero
  assign control_view = {control_reg[7:5], status_reg, // R5
    control_reg[`CMPCTL_BIT_OUTPUT_ROUTE], 2'b00, // R7
    control_reg[`CMPCTL_BIT_HYSTERESIS_ON]};

  // ========================================================================
  // Register write logic
  // ========================================================================
  always_comb begin
    control_next = control_reg;
    enable_next = enable_reg;
    port_data_next = port_data_reg;
    port_control_next = port_control_reg;
    port_pullhigh_next = port_pullhigh_reg;
    if (wr && hit_control && i_wb_sel[0]) begin
      // Status and unimplemented bits ignore writes
      control_next = {i_wb_dat[7:5], 1'b0, i_wb_dat[3], 2'b00,
        i_wb_dat[0]}; // R7
    end else if (wr && hit_event && i_wb_sel[0]) begin
      enable_next = i_wb_dat[`CMPCTL_BIT_EVENT_ENABLE];
    end else if (wr && hit_port) begin
      if (i_wb_sel[0]) begin
        port_data_next = i_wb_dat[`CMPCTL_LSB_PORT_DATA +: 3];
        port_control_next = i_wb_dat[`CMPCTL_LSB_PORT_CONTROL +: 3];
      end
      if (i_wb_sel[1]) begin
        port_pullhigh_next = i_wb_dat[`CMPCTL_LSB_PORT_PULLHIGH +: 3];
      end
    end
  end

  // Flag write travels to the event block, where a change still wins
  assign flag_we = wr & hit_event & i_wb_sel[0];

  // ========================================================================
  // Read data selection, taken at the same edge as the request
  // ========================================================================
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_control) begin
      rdata_next[7:0] = control_view; // R5
    end else if (hit_event) begin
      rdata_next[`CMPCTL_BIT_EVENT_FLAG] = flag;
      rdata_next[`CMPCTL_BIT_EVENT_ENABLE] = enable_reg;
    end else if (hit_port) begin
      rdata_next[`CMPCTL_LSB_PORT_DATA +: 3] = port_data_reg;
      rdata_next[`CMPCTL_LSB_PORT_CONTROL +: 3] = port_control_reg;
      rdata_next[`CMPCTL_LSB_PORT_PULLHIGH +: 3] = port_pullhigh_reg;
    end else if (hit_pin_read) begin
      rdata_next[2:0] = pin_read; // R10
    end
  end

  // ========================================================================
  // Answer sequencer: one ack per request, then a forced idle cycle
  // ========================================================================
  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      CMPCTL_BUS_IDLE: begin
        if (request) begin
          bus_state_next = CMPCTL_BUS_ACK;
        end
      end
      CMPCTL_BUS_ACK: begin
        // Ack lasts one cycle whatever the master does
        bus_state_next = CMPCTL_BUS_IDLE;
      end
      default: begin
        bus_state_next = CMPCTL_BUS_IDLE;
      end
    endcase
  end

  // Bus and sequencer flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_state_reg <= CMPCTL_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
    end else begin
      bus_state_reg <= bus_state_next;
      if (request) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Control and port flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      control_reg <= `CMPCTL_CONTROL_RESET; // R1
      enable_reg <= 1'b0;
      port_data_reg <= `CMPCTL_PORT_DATA_RESET;
      port_control_reg <= `CMPCTL_PORT_CONTROL_RESET;
      port_pullhigh_reg <= `CMPCTL_PORT_PULLHIGH_RESET;
    end else begin
      control_reg <= control_next;
      enable_reg <= enable_next;
      port_data_reg <= port_data_next;
      port_control_reg <= port_control_next;
      port_pullhigh_reg <= port_pullhigh_next;
    end
  end

  // Result sampled every cycle so the status bit never glitches mid-read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_reg <= 1'b0;
    end else begin
      status_reg <= status_next; // R4
    end
  end

  assign o_wb_ack = bus_state_reg == CMPCTL_BUS_ACK;
  assign o_wb_dat = rdata_reg;
  assign o_comparator_on = ctrl.comparator_on; // R3
  assign o_hysteresis_on = ctrl.hysteresis_on; // R7

  // ========================================================================
  // Sub-blocks
  // ========================================================================
  cmpctl_event u_event (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_status(status_reg),
    .i_comparator_on(ctrl.comparator_on),
    .i_low_power(i_low_power),
    .i_flag_we(flag_we),
    .i_flag_wdata(i_wb_dat[`CMPCTL_BIT_EVENT_FLAG]),
    .i_enable(enable_reg),
    .o_flag(flag),
    .o_irq(o_irq),
    .o_wake(o_wake)
  );

  cmpctl_pinmux u_pinmux (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ctrl(ctrl),
    .i_status(status_reg),
    .i_port_data(port_data_reg),
    .i_port_control(port_control_reg),
    .i_port_pullhigh(port_pullhigh_reg),
    .i_pin_in(i_pin_in),
    .o_pins(o_pins),
    .o_pin_read(pin_read)
  );

  // ========================================================================
  // Checks
  // ========================================================================
  property p_reset_value;
    @(posedge i_clk)
    $fell(i_rst) |-> ctrl.pin_select && !ctrl.comparator_on
      && ctrl.hysteresis_on && !ctrl.output_route_select;
  endproperty
  a_reset_value: assert property (p_reset_value) // R1
    else $error("control reset value wrong");

  property p_power_off;
    @(posedge i_clk) disable iff (i_rst)
    // Status lags the control by one cycle, so compare the old polarity
    !o_comparator_on |=>
      status_reg == $past(ctrl.output_polarity);
  endproperty
  a_power_off: assert property (p_power_off) // R3
    else $error("result seen while core switched off");

  property p_polarity;
    @(posedge i_clk) disable iff (i_rst)
    $past(o_comparator_on) |->
      status_reg == ($past(i_core_result) ^ $past(ctrl.output_polarity));
  endproperty
  a_polarity: assert property (p_polarity) // R4
    else $error("status does not follow result and polarity");

  property p_status_read;
    @(posedge i_clk) disable iff (i_rst)
    request && !i_wb_we && hit_control |=>
      o_wb_ack && o_wb_dat[4] == $past(status_reg)
      && o_wb_dat[31:8] == 24'h00_0000;
  endproperty
  a_status_read: assert property (p_status_read) // R5
    else $error("status bit read back wrong");

  property p_unimpl_zero;
    @(posedge i_clk) disable iff (i_rst)
    request && hit_control |=> control_reg[2:1] == 2'b00
      && control_reg[4] == 1'b0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // R7
    else $error("unimplemented control bits stored");

  property p_ack_once;
    @(posedge i_clk) disable iff (i_rst)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack not a single cycle after request");

endmodule : cmpctl_top

// ### verification/cmpctl_core_model.sv
// Behavioural analog core and pad model facing the comparator block
module cmpctl_core_model (
  input wire logic i_clk,
  input wire logic i_above, // Positive input above negative
  input wire logic i_on,
  input wire cmpctl_pkg::cmpctl_pins_s i_pins,
  output logic o_result,
  output logic [2:0] o_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmpctl_pkg::*;
  // ==========================================================
  // Core output
  // ==========================================================
  logic junk_reg = 1'b0; // Powered-down core gives no usable level
  // Toggle so an unpowered result is never silently a clean 0
  always @(posedge i_clk) begin
    junk_reg <= ~junk_reg;
  end
  assign o_result = i_on ? i_above : junk_reg;
  // ==========================================================
  // Pads: driven, pulled high, else floating
  // ==========================================================
  // Floating pads alternate so no level is assumed
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (i_pins.oe[k]) begin
        o_pin_in[k] = i_pins.out[k];
      end else if (i_pins.pullhigh[k]) begin
        o_pin_in[k] = 1'b1;
      end else begin
        o_pin_in[k] = junk_reg;
      end
    end
  end
endmodule : cmpctl_core_model

// ### verification/comparator_control_register_test.sv
// Self-checking bench of the comparator control register block
module comparator_control_register_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cmpctl_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic i_clk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic we = 1'b0, lowp = 1'b0, above = 1'b0, res, on, hyst;
  logic ack, irq, wake;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [2:0] pin_in;
  cmpctl_pins_s pins;
  int error_cnt = 0, check_count = 0;
  always #20 i_clk = ~i_clk; // 25 MHz
  cmpctl_top cmpctl_top_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_core_result(res), .o_comparator_on(on), .o_hysteresis_on(hyst),
    .i_pin_in(pin_in), .o_pins(pins), .i_low_power(lowp), .o_irq(irq),
    .o_wake(wake));
  cmpctl_core_model cmpctl_core_model_inst (.i_clk(i_clk),
    .i_above(above), .i_on(on), .i_pins(pins), .o_result(res),
    .o_pin_in(pin_in));
  // ==========================================================
  // Bus and compare helpers
  // ==========================================================
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge i_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : wt
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Reads a register and compares the whole word
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask : rchk
  // Counts wake pulses over a short span
  task automatic wakes(input int e);
    int c;
    c = 0;
    repeat (6) begin
      @(negedge i_clk);
      if (wake !== 1'b0) c++;
    end
    chk("wake count", e, c);
  endtask : wakes
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_ctrl();
    rchk(4'h0, 32'h81);
    chk("pin oe", 32'h4, {29'h0, pins.oe});
    above <= 1'b1;
    wb(1'b1, 4'h0, 32'hffff_ffde);
    wt(2);
    rchk(4'h0, 32'hd8);
    chk("hysteresis", 32'h0, {31'h0, hyst});
    wb(1'b1, 4'h0, 32'he1);
    wt(2);
    rchk(4'h0, 32'he1);
    above <= 1'b0;
    wt(3);
    rchk(4'h0, 32'hf1);
  endtask : t_ctrl
  task automatic t_route();
    wb(1'b1, 4'h0, 32'hc1);
    wt(3);
    chk("oe", 32'h4, {29'h0, pins.oe});
    chk("out2", 32'h0, {31'h0, pins.out[2]});
    @(posedge i_clk);
    above <= 1'b1;
    wt(3);
    chk("out2", 32'h1, {31'h0, pins.out[2]});
    wb(1'b1, 4'h0, 32'hc9);
    wt(1);
    chk("oe", 32'h0, {29'h0, pins.oe});
    wb(1'b1, 4'h0, 32'h41);
    wt(1);
    chk("oe", 32'h0, {29'h0, pins.oe});
    wb(1'b1, 4'h0, 32'ha1);
    wt(3);
    chk("core on", 32'h0, {31'h0, on});
    rchk(4'h0, 32'hb1);
  endtask : t_route
  task automatic t_event();
    above <= 1'b0;
    wb(1'b1, 4'h0, 32'hc1);
    wt(3);
    wb(1'b1, 4'h4, 32'h2);
    rchk(4'h4, 32'h2);
    above <= 1'b1;
    wt(3);
    chk("irq", 32'h1, {31'h0, irq});
    rchk(4'h4, 32'h3);
    lowp <= 1'b1;
    wb(1'b1, 4'h4, 32'h0);
    above <= 1'b0;
    wakes(1);
    wb(1'b1, 4'h4, 32'h1);
    above <= 1'b1;
    wakes(0);
    @(posedge i_clk);
    lowp <= 1'b0;
  endtask : t_event
  task automatic t_port();
    wb(1'b1, 4'h0, 32'h89);
    wb(1'b1, 4'h8, 32'h705);
    wt(2);
    rchk(4'hc, 32'h5);
    chk("oe", 32'h4, {29'h0, pins.oe});
    wb(1'b1, 4'h8, 32'h775);
    wt(2);
    chk("pullhigh", 32'h4, {29'h0, pins.pullhigh});
    rchk(4'hc, 32'h4);
  endtask : t_port
  // ==========================================================
  // Verdict, watchdog and main sequence
  // ==========================================================
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_ctrl();
    t_route();
    t_event();
    t_port();
    test_done();
  end
endmodule : comparator_control_register_test
